// ==== design/ivop_unit.sv ====
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module ivop_unit
	import ivop_pkg::*;
(
	input  logic        pclk,
	input  logic        presetn,
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [31:0] paddr,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic        pready_q,
	output logic        pslverr_q,
	input  logic        op_valid,
	output logic        op_ready_q,
	input  ivop_op_t    op_code,
	input  logic [2:0]  src_a_idx,
	input  logic [2:0]  src_b_idx,
	input  logic [2:0]  dst_idx,
	input  logic        uses_a,
	input  logic        uses_b,
	input  logic        pushes,
	input  ivop_cls_t   a_cls,
	input  logic        a_sign,
	input  ivop_cls_t   b_cls,
	input  logic        b_sign,
	input  logic        below_neg_one,
	input  logic        range_ovf,
	input  logic [15:0] tag_word,
	output logic        done_q,
	output logic        invalid_q,
	output logic        stack_fault_exception_q,
	output logic        invalid_arith_exception_q,
	output logic        handler_req_q,
	output logic        commit_q,
	output ivop_res_t   result_sel_q,
	output logic        fill_a_q,
	output logic        fill_b_q,
	output logic        int_flag_we_q,
	output logic [2:0]  int_flags_q,
	output logic [15:0] status_word_q
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	ivop_state_t state_q;
	ivop_state_t state_d;
	logic [15:0] ctrl_q;
	logic [15:0] stat_d;
	ivop_op_t    op_q;
	ivop_cls_t   a_cls_q;
	ivop_cls_t   b_cls_q;
	logic        a_sign_q;
	logic        b_sign_q;
	logic        uses_a_q;
	logic        uses_b_q;
	logic        pushes_q;
	logic        below_q;
	logic        range_q;
	logic [1:0]  tag_a_q;
	logic [1:0]  tag_b_q;
	logic [1:0]  tag_dst_q;
	logic        take;
	logic        eval;
	logic        ovf;
	logic        unf;
	logic        sf_ev;
	logic        ar_inv;
	ivop_res_t   ar_res;
	logic        ar_clr_c2;
	logic        inv_ev;
	logic        masked;
	ivop_res_t   res_sel;
	logic        setup;
	logic        access;
	logic        mapped;
	logic        wr_ctrl;
	logic        wr_stat;

	function automatic ivop_res_t stack_res(input ivop_op_t op);
		case (op)
			OP_INT_ST:                     stack_res = RES_INT_INDEF;
			OP_BCD_ST:                     stack_res = RES_BCD_INDEF;
			OP_CMP, OP_CMP_FLAGS, OP_UCMP: stack_res = RES_UNORDERED;
			default:                       stack_res = RES_QNAN_INDEF;
		endcase
	endfunction

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign setup   = psel & ~penable;
	assign access  = psel & penable & pready_q;
	assign mapped  = (paddr == ADDR_CTRL) | (paddr == ADDR_STAT) | (paddr == ADDR_TAG);
	assign wr_ctrl = access & pwrite & (paddr == ADDR_CTRL) & ~pslverr_q;
	assign wr_stat = access & pwrite & (paddr == ADDR_STAT) & ~pslverr_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
		else if (setup)
		begin
			pready_q  <= 1'b1;
			pslverr_q <= ~mapped;
			if (paddr == ADDR_CTRL)
				prdata_q <= {16'h0000, ctrl_q};
			else if (paddr == ADDR_STAT)
				prdata_q <= {16'h0000, status_word_q};
			else if (paddr == ADDR_TAG)
				prdata_q <= {16'h0000, tag_word};
			else
				prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Control word
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_q <= CTRL_RST;
		else if (wr_ctrl)
			ctrl_q <= pwdata[15:0] & CTRL_WMASK;
	end

	assign masked = ctrl_q[IM_BIT];

	// ----------------------------------------
	// Request handshake and sequencing
	// ----------------------------------------
	assign take = op_valid & op_ready_q;
	assign eval = (state_q == ST_EVAL);

	always_comb
	begin
		case (state_q)
			ST_IDLE: state_d = take ? ST_EVAL : ST_IDLE;
			ST_EVAL: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q    <= ST_IDLE;
			op_ready_q <= 1'b1;
		end
		else
		begin
			state_q    <= state_d;
			op_ready_q <= (state_d == ST_IDLE);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op_q      <= OP_OTHER;
			a_cls_q   <= CLS_FINITE;
			b_cls_q   <= CLS_FINITE;
			a_sign_q  <= 1'b0;
			b_sign_q  <= 1'b0;
			uses_a_q  <= 1'b0;
			uses_b_q  <= 1'b0;
			pushes_q  <= 1'b0;
			below_q   <= 1'b0;
			range_q   <= 1'b0;
			tag_a_q   <= TAG_EMPTY;
			tag_b_q   <= TAG_EMPTY;
			tag_dst_q <= TAG_EMPTY;
		end
		else if (take)
		begin
			op_q      <= op_code;
			a_cls_q   <= a_cls;
			b_cls_q   <= b_cls;
			a_sign_q  <= a_sign;
			b_sign_q  <= b_sign;
			uses_a_q  <= uses_a;
			uses_b_q  <= uses_b;
			pushes_q  <= pushes;
			below_q   <= below_neg_one;
			range_q   <= range_ovf;
			tag_a_q   <= tag_word[{src_a_idx, 1'b0} +: 2];
			tag_b_q   <= tag_word[{src_b_idx, 1'b0} +: 2];
			tag_dst_q <= tag_word[{dst_idx, 1'b0} +: 2];
		end
	end

	// ----------------------------------------
	// Detection
	// ----------------------------------------
	ivop_stack_check u_stack (
		.uses_a    (uses_a_q),
		.uses_b    (uses_b_q),
		.pushes    (pushes_q),
		.tag_a     (tag_a_q),
		.tag_b     (tag_b_q),
		.tag_dst   (tag_dst_q),
		.overflow  (ovf),
		.underflow (unf)
	);

	ivop_arith_check u_arith (
		.op            (op_q),
		.a_cls         (a_cls_q),
		.a_sign        (a_sign_q),
		.b_cls         (b_cls_q),
		.b_sign        (b_sign_q),
		.below_neg_one (below_q),
		.range_ovf     (range_q),
		.invalid       (ar_inv),
		.result        (ar_res),
		.clr_c2        (ar_clr_c2)
	);

	assign sf_ev   = ovf | unf;
	assign inv_ev  = sf_ev | ar_inv;
	assign res_sel = sf_ev ? stack_res(op_q) : ar_res;

	// ----------------------------------------
	// Status word
	// ----------------------------------------
	always_comb
	begin
		stat_d = status_word_q;
		if (wr_stat)
			stat_d = pwdata[15:0] & STAT_WMASK;
		if (eval && inv_ev)
		begin
			stat_d[IE_BIT] = 1'b1;
			if (sf_ev)
			begin
				stat_d[SF_BIT] = 1'b1;
				stat_d[C1_BIT] = ovf;
			end
			if (!masked)
				stat_d[ES_BIT] = 1'b1;
			else
			begin
				if (res_sel == RES_UNORDERED && op_q != OP_CMP_FLAGS)
				begin
					stat_d[C0_BIT] = UNORDERED_CC[0];
					stat_d[C2_BIT] = UNORDERED_CC[1];
					stat_d[C3_BIT] = UNORDERED_CC[2];
				end
				if (!sf_ev && ar_clr_c2)
					stat_d[C2_BIT] = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_word_q <= STAT_RST;
		else
			status_word_q <= stat_d;
	end

	// ----------------------------------------
	// Response to the pipeline
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_q                    <= 1'b0;
			invalid_q                 <= 1'b0;
			stack_fault_exception_q   <= 1'b0;
			invalid_arith_exception_q <= 1'b0;
			handler_req_q             <= 1'b0;
			commit_q                  <= 1'b0;
			result_sel_q              <= RES_NONE;
			fill_a_q                  <= 1'b0;
			fill_b_q                  <= 1'b0;
			int_flag_we_q             <= 1'b0;
			int_flags_q               <= 3'h0;
		end
		else
		begin
			done_q                    <= eval;
			invalid_q                 <= eval & inv_ev;
			stack_fault_exception_q   <= eval & sf_ev;
			invalid_arith_exception_q <= eval & ar_inv & ~sf_ev;
			handler_req_q             <= eval & inv_ev & ~masked;
			commit_q                  <= eval & ~(inv_ev & ~masked);
			result_sel_q              <= (eval & inv_ev & masked) ? res_sel : RES_NONE;
			fill_a_q                  <= eval & masked & (op_q == OP_XCH)
			                             & (tag_a_q == TAG_EMPTY);
			fill_b_q                  <= eval & masked & (op_q == OP_XCH)
			                             & (tag_b_q == TAG_EMPTY);
			int_flag_we_q             <= eval & inv_ev & masked
			                             & (op_q == OP_CMP_FLAGS);
			int_flags_q               <= (eval & inv_ev & masked & (op_q == OP_CMP_FLAGS))
			                             ? UNORDERED_CC : 3'h0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_ie_set;
		@(posedge pclk) disable iff (!presetn)
		eval && inv_ev |=> status_word_q[IE_BIT] && invalid_q && done_q;
	endproperty
	a_ie_set: assert property (p_ie_set) else $error("invalid flag not set");

	property p_sf_set;
		@(posedge pclk) disable iff (!presetn)
		eval && sf_ev |=> status_word_q[SF_BIT] && stack_fault_exception_q;
	endproperty
	a_sf_set: assert property (p_sf_set) else $error("stack fault flag not set");

	property p_sf_kept;
		@(posedge pclk) disable iff (!presetn)
		eval && ar_inv && !sf_ev && status_word_q[SF_BIT] && !wr_stat
		|=> status_word_q[SF_BIT] && invalid_arith_exception_q;
	endproperty
	a_sf_kept: assert property (p_sf_kept) else $error("stack fault flag cleared");

	property p_dir_bit;
		@(posedge pclk) disable iff (!presetn)
		eval && sf_ev |=> status_word_q[C1_BIT] == $past(ovf);
	endproperty
	a_dir_bit: assert property (p_dir_bit) else $error("direction bit wrong");

	property p_unmasked;
		@(posedge pclk) disable iff (!presetn)
		eval && inv_ev && !masked
		|=> handler_req_q && !commit_q && status_word_q[ES_BIT] && result_sel_q == RES_NONE;
	endproperty
	a_unmasked: assert property (p_unmasked) else $error("unmasked response wrong");

	property p_masked;
		@(posedge pclk) disable iff (!presetn)
		eval && inv_ev && masked && !wr_stat && !status_word_q[ES_BIT]
		|=> !handler_req_q && commit_q && !status_word_q[ES_BIT] && result_sel_q != RES_NONE;
	endproperty
	a_masked: assert property (p_masked) else $error("masked response wrong");

	property p_unordered;
		@(posedge pclk) disable iff (!presetn)
		done_q && result_sel_q == RES_UNORDERED && !int_flag_we_q
		|-> status_word_q[C0_BIT] && status_word_q[C2_BIT] && status_word_q[C3_BIT];
	endproperty
	a_unordered: assert property (p_unordered) else $error("unordered codes not set");

	property p_overflow;
		@(posedge pclk) disable iff (!presetn)
		take && pushes && tag_word[{dst_idx, 1'b0} +: 2] != TAG_EMPTY
		|-> ##2 stack_fault_exception_q && status_word_q[C1_BIT];
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow missed");

	property p_underflow;
		@(posedge pclk) disable iff (!presetn)
		take && uses_a && !(pushes && tag_word[{dst_idx, 1'b0} +: 2] != TAG_EMPTY)
		&& tag_word[{src_a_idx, 1'b0} +: 2] == TAG_EMPTY
		|-> ##2 stack_fault_exception_q && !status_word_q[C1_BIT];
	endproperty
	a_underflow: assert property (p_underflow) else $error("underflow missed");

	property p_timing;
		@(posedge pclk) disable iff (!presetn)
		take |=> !op_ready_q ##1 done_q && op_ready_q;
	endproperty
	a_timing: assert property (p_timing) else $error("answer timing wrong");

endmodule

// ==== design/ivop_pkg.sv ====
package ivop_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [31:0] ADDR_CTRL      = 32'h0000_0000;
	localparam logic [31:0] ADDR_STAT      = 32'h0000_0004;
	localparam logic [31:0] ADDR_TAG       = 32'h0000_0008;
	localparam logic [15:0] CTRL_RST       = 16'h0001;
	localparam logic [15:0] STAT_RST       = 16'h0000;
	localparam logic [15:0] CTRL_WMASK     = 16'h0001;
	localparam logic [15:0] STAT_WMASK     = 16'h47C1;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int unsigned IM_BIT         = 0;
	localparam int unsigned IE_BIT         = 0;
	localparam int unsigned SF_BIT         = 6;
	localparam int unsigned ES_BIT         = 7;
	localparam int unsigned C0_BIT         = 8;
	localparam int unsigned C1_BIT         = 9;
	localparam int unsigned C2_BIT         = 10;
	localparam int unsigned C3_BIT         = 14;

	// ----------------------------------------
	// Tag codes and condition values
	// ----------------------------------------
	localparam logic [1:0]  TAG_VALID      = 2'h0;
	localparam logic [1:0]  TAG_ZERO       = 2'h1;
	localparam logic [1:0]  TAG_SPECIAL    = 2'h2;
	localparam logic [1:0]  TAG_EMPTY      = 2'h3;
	localparam logic [2:0]  UNORDERED_CC   = 3'h7;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [4:0] {
		OP_OTHER = 5'h00, OP_LOAD = 5'h01, OP_STORE_FP = 5'h02, OP_ADD = 5'h03,
		OP_SUB = 5'h04, OP_MUL = 5'h05, OP_DIV = 5'h06, OP_PREM = 5'h07,
		OP_TRIG = 5'h08, OP_SQRT = 5'h09, OP_YLOG = 5'h0A, OP_YLOGP1 = 5'h0B,
		OP_BCD_ST = 5'h0C, OP_INT_ST = 5'h0D, OP_XCH = 5'h0E, OP_CMP = 5'h0F,
		OP_CMP_FLAGS = 5'h10, OP_UCMP = 5'h11
	} ivop_op_t;

	typedef enum logic [2:0] {
		CLS_FINITE = 3'h0, CLS_ZERO = 3'h1, CLS_INF = 3'h2,
		CLS_QNAN = 3'h3, CLS_SNAN = 3'h4, CLS_UNSUP = 3'h5
	} ivop_cls_t;

	typedef enum logic [2:0] {
		RES_NONE = 3'h0, RES_QNAN_INDEF = 3'h1, RES_QUIET_NAN = 3'h2,
		RES_INT_INDEF = 3'h3, RES_BCD_INDEF = 3'h4, RES_UNORDERED = 3'h5
	} ivop_res_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EVAL = 2'b10
	} ivop_state_t;

endpackage

// ==== design/ivop_stack_check.sv ====
`timescale 1ns/1ps
module ivop_stack_check
	import ivop_pkg::*;
(
	input  logic       uses_a,
	input  logic       uses_b,
	input  logic       pushes,
	input  logic [1:0] tag_a,
	input  logic [1:0] tag_b,
	input  logic [1:0] tag_dst,
	output logic       overflow,
	output logic       underflow
);

	// ----------------------------------------
	// Tag based stack fault detection
	// ----------------------------------------
	assign overflow  = pushes & (tag_dst != TAG_EMPTY);
	assign underflow = (uses_a & (tag_a == TAG_EMPTY)) | (uses_b & (tag_b == TAG_EMPTY));

endmodule

// ==== design/ivop_arith_check.sv ====
`timescale 1ns/1ps
module ivop_arith_check
	import ivop_pkg::*;
(
	input  ivop_op_t  op,
	input  ivop_cls_t a_cls,
	input  logic      a_sign,
	input  ivop_cls_t b_cls,
	input  logic      b_sign,
	input  logic      below_neg_one,
	input  logic      range_ovf,
	output logic      invalid,
	output ivop_res_t result,
	output logic      clr_c2
);

	logic any_snan;
	logic any_qnan;
	logic any_unsup;
	logic a_inf;
	logic b_inf;
	logic a_zero;
	logic b_zero;
	logic a_neg;
	logic op_inv;

	assign any_snan  = (a_cls == CLS_SNAN) | (b_cls == CLS_SNAN);
	assign any_qnan  = (a_cls == CLS_QNAN) | (b_cls == CLS_QNAN);
	assign any_unsup = (a_cls == CLS_UNSUP) | (b_cls == CLS_UNSUP);
	assign a_inf     = (a_cls == CLS_INF);
	assign b_inf     = (b_cls == CLS_INF);
	assign a_zero    = (a_cls == CLS_ZERO);
	assign b_zero    = (b_cls == CLS_ZERO);
	assign a_neg     = a_sign & ((a_cls == CLS_FINITE) | a_inf);

	// ----------------------------------------
	// Operation specific invalid cases
	// ----------------------------------------
	always_comb
	begin
		case (op)
			OP_ADD:    op_inv = a_inf & b_inf & (a_sign != b_sign);
			OP_SUB:    op_inv = a_inf & b_inf & (a_sign == b_sign);
			OP_MUL:    op_inv = (a_inf & b_zero) | (a_zero & b_inf);
			OP_DIV:    op_inv = (a_inf & b_inf) | (a_zero & b_zero);
			OP_PREM:   op_inv = b_zero | a_inf;
			OP_TRIG:   op_inv = a_inf;
			OP_SQRT:   op_inv = a_neg;
			OP_YLOG:   op_inv = a_neg;
			OP_YLOGP1: op_inv = below_neg_one;
			default:   op_inv = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Invalid decision and masked default
	// ----------------------------------------
	always_comb
	begin
		invalid = 1'b0;
		result  = RES_NONE;
		clr_c2  = 1'b0;
		case (op)
			OP_INT_ST:
			begin
				invalid = any_snan | any_qnan | (a_inf | b_inf) | any_unsup | range_ovf;
				result  = RES_INT_INDEF;
			end
			OP_BCD_ST:
			begin
				invalid = any_snan | any_qnan | (a_inf | b_inf) | any_unsup | range_ovf;
				result  = RES_BCD_INDEF;
			end
			OP_CMP, OP_CMP_FLAGS:
			begin
				invalid = any_snan | any_qnan | any_unsup;
				result  = RES_UNORDERED;
			end
			OP_UCMP:
			begin
				invalid = any_snan | any_unsup;
				result  = RES_UNORDERED;
			end
			OP_XCH, OP_OTHER:
			begin
				invalid = 1'b0;
			end
			default:
			begin
				if (any_unsup)
				begin
					invalid = 1'b1;
					result  = RES_QNAN_INDEF;
				end
				else if (any_snan)
				begin
					invalid = 1'b1;
					result  = RES_QUIET_NAN;
				end
				else if (op_inv)
				begin
					invalid = 1'b1;
					result  = RES_QNAN_INDEF;
					clr_c2  = (op == OP_PREM) | (op == OP_TRIG);
				end
			end
		endcase
	end

endmodule

// ==== test/ivop_pipe_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Pipeline side: offers one op per start
// ----------------------------------------
module ivop_pipe_model
(
	input  logic       pclk,
	input  logic       presetn,
	input  logic       start,
	input  logic [1:0] lag,
	input  logic       op_ready_q,
	input  logic       done_q,
	output logic       op_valid_q,
	output logic       busy_q
);
	logic       sent_q;
	logic [1:0] wait_q;

	// Request held until taken, then wait for the answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op_valid_q <= 1'b0;
			busy_q     <= 1'b0;
			sent_q     <= 1'b0;
			wait_q     <= 2'h0;
		end
		else if (start && !busy_q)
			{busy_q, sent_q, wait_q} <= {1'b1, 1'b0, lag};
		else if (busy_q && !sent_q && wait_q != 2'h0)
			wait_q <= wait_q - 2'h1;
		else if (busy_q && !sent_q)
			{op_valid_q, sent_q} <= 2'h3;
		else if (op_valid_q && op_ready_q)
			op_valid_q <= 1'b0;
		else if (done_q)
			busy_q <= 1'b0;
	end
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench
	import ivop_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, start, err, unm, ld, f;
	logic [31:0] paddr, pwdata, prdata_q, rd;
	logic        pready_q, pslverr_q, op_valid, op_ready_q, busy_q;
	ivop_op_t    op_code;
	ivop_cls_t   a_cls, b_cls;
	logic [2:0]  src_a_idx, src_b_idx, dst_idx, ia, ib, id, int_flags_q;
	logic        uses_a, uses_b, pushes, a_sign, b_sign, below_neg_one, range_ovf;
	logic [15:0] tag_word, status_word_q, tw;
	logic        done_q, invalid_q, stack_fault_exception_q, invalid_arith_exception_q;
	logic        handler_req_q, commit_q, fill_a_q, fill_b_q, int_flag_we_q;
	ivop_res_t   result_sel_q;
	logic [1:0]  lag;
	logic [9:0]  seen;
	logic [3:0]  iflags;
	int          errors, n_tests;

	ivop_unit ivop_unit_i(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata_q, .pready_q, .pslverr_q, .op_valid, .op_ready_q, .op_code, .src_a_idx,
		.src_b_idx, .dst_idx, .uses_a, .uses_b, .pushes, .a_cls, .a_sign, .b_cls, .b_sign,
		.below_neg_one, .range_ovf, .tag_word, .done_q, .invalid_q, .stack_fault_exception_q,
		.invalid_arith_exception_q, .handler_req_q, .commit_q, .result_sel_q, .fill_a_q,
		.fill_b_q, .int_flag_we_q, .int_flags_q, .status_word_q);
	ivop_pipe_model ivop_pipe_model_i(.pclk, .presetn, .start, .lag, .op_ready_q, .done_q,
		.op_valid_q(op_valid), .busy_q);

	// ----------------------------------------
	// Clock, checks and bus cycles
	// ----------------------------------------
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	function automatic logic [9:0] exp_out(input logic inv, input logic [1:0] sf,
		input ivop_res_t res, input logic [1:0] fill);
		logic h;
		h = inv & unm;
		return {inv, inv & sf[1], inv & !sf[1], h, !h, h ? RES_NONE : res, h ? 2'h0 : fill};
	endfunction

	function automatic logic fault_exp(input logic load, input logic [15:0] t,
		input logic [2:0] i);
		return load ? (t[2*i +: 2] != TAG_EMPTY) : (t[2*i +: 2] == TAG_EMPTY);
	endfunction

	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		int k = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready_q !== 1'b1 && ++k < 50);
		if (k >= 50)
			errors++;
		rd = prdata_q;
		err = pslverr_q;
		{psel, penable} <= 2'h0;
	endtask

	task automatic run_op(input ivop_op_t op, input ivop_cls_t ac, input logic as,
		input ivop_cls_t bc, input logic bs, input logic [4:0] fl, input logic inv,
		input logic [1:0] sf, input ivop_res_t res, input logic [1:0] fill);
		int k = 0;
		@(posedge pclk);
		{op_code, a_cls, a_sign, b_cls, b_sign} <= {op, ac, as, bc, bs};
		{uses_a, uses_b, pushes, below_neg_one, range_ovf} <= fl;
		{src_a_idx, src_b_idx, dst_idx, tag_word} <= {ia, ib, id, tw};
		lag <= 2'($urandom_range(3));
		start <= 1'b1;
		@(posedge pclk);
		start <= 1'b0;
		do
			@(posedge pclk);
		while (done_q !== 1'b1 && ++k < 20);
		if (k >= 20)
			errors++;
		seen = {invalid_q, stack_fault_exception_q, invalid_arith_exception_q, handler_req_q,
			commit_q, result_sel_q, fill_a_q, fill_b_q};
		iflags = {int_flag_we_q, int_flags_q};
		chk("op_out", 32'(seen), 32'(exp_out(inv, sf, res, fill)));
		if (inv)
			chk("status_ie_es", 32'({status_word_q[IE_BIT], status_word_q[ES_BIT]}),
				32'({1'b1, unm}));
		if (sf[1])
			chk("status_sf_c1", 32'({status_word_q[SF_BIT], status_word_q[C1_BIT]}),
				32'({1'b1, sf[0]}));
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, start, lag} = '0;
		{op_code, a_cls, b_cls} = {OP_OTHER, CLS_FINITE, CLS_FINITE};
		{src_a_idx, src_b_idx, dst_idx, uses_a, uses_b, pushes} = '0;
		{a_sign, b_sign, below_neg_one, range_ovf, tag_word} = '0;
		{errors, n_tests, ia, ib, id, tw, unm} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		void'($urandom(16413));
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl_rst", rd, 32'(CTRL_RST));
		apb(1'b0, ADDR_STAT, 32'h0);
		chk("stat_rst", rd, 32'(STAT_RST));
		apb(1'b1, 32'h0000_000C, 32'hFFFF_FFFF);
		chk("unmapped", {31'(rd), err}, 32'h1);
		$display("test registers done");
		run_op(OP_LOAD, CLS_FINITE, 0, CLS_FINITE, 0, 5'h04, 1, 2'h3, RES_QNAN_INDEF, 0);
		tw = 16'hFFFF;
		run_op(OP_LOAD, CLS_FINITE, 0, CLS_FINITE, 0, 5'h04, 0, 2'h0, RES_NONE, 0);
		run_op(OP_INT_ST, CLS_FINITE, 0, CLS_FINITE, 0, 5'h10, 1, 2'h2, RES_INT_INDEF, 0);
		run_op(OP_BCD_ST, CLS_FINITE, 0, CLS_FINITE, 0, 5'h10, 1, 2'h2, RES_BCD_INDEF, 0);
		{tw, ib} = {16'h000C, 3'h1};
		run_op(OP_XCH, CLS_FINITE, 0, CLS_FINITE, 0, 5'h18, 1, 2'h2, RES_QNAN_INDEF, 1);
		{tw, ib} = '0;
		run_op(OP_ADD, CLS_INF, 0, CLS_INF, 1, 5'h18, 1, 2'h0, RES_QNAN_INDEF, 0);
		chk("sf_kept", 32'(status_word_q[SF_BIT]), 32'h1);
		apb(1'b1, ADDR_STAT, 32'h0);
		run_op(OP_SUB, CLS_INF, 1, CLS_INF, 1, 5'h18, 1, 2'h0, RES_QNAN_INDEF, 0);
		chk("sf_clear", 32'(status_word_q[SF_BIT]), 32'h0);
		run_op(OP_ADD, CLS_INF, 0, CLS_INF, 0, 5'h18, 0, 2'h0, RES_NONE, 0);
		run_op(OP_MUL, CLS_INF, 0, CLS_ZERO, 0, 5'h18, 1, 2'h0, RES_QNAN_INDEF, 0);
		run_op(OP_DIV, CLS_INF, 0, CLS_INF, 0, 5'h18, 1, 2'h0, RES_QNAN_INDEF, 0);
		run_op(OP_DIV, CLS_ZERO, 0, CLS_ZERO, 1, 5'h18, 1, 2'h0, RES_QNAN_INDEF, 0);
		run_op(OP_ADD, CLS_UNSUP, 0, CLS_FINITE, 0, 5'h18, 1, 2'h0, RES_QNAN_INDEF, 0);
		run_op(OP_MUL, CLS_SNAN, 0, CLS_FINITE, 0, 5'h18, 1, 2'h0, RES_QUIET_NAN, 0);
		run_op(OP_ADD, CLS_QNAN, 0, CLS_FINITE, 0, 5'h18, 0, 2'h0, RES_NONE, 0);
		run_op(OP_UCMP, CLS_QNAN, 0, CLS_FINITE, 0, 5'h18, 0, 2'h0, RES_NONE, 0);
		run_op(OP_CMP_FLAGS, CLS_QNAN, 0, CLS_FINITE, 0, 5'h18, 1, 2'h0, RES_UNORDERED, 0);
		chk("int_flags", 32'(iflags), 32'hF);
		run_op(OP_CMP, CLS_FINITE, 0, CLS_QNAN, 0, 5'h18, 1, 2'h0, RES_UNORDERED, 0);
		chk("cc_unord", 32'({status_word_q[C3_BIT], status_word_q[C2_BIT],
			status_word_q[C0_BIT]}), 32'(UNORDERED_CC));
		run_op(OP_PREM, CLS_INF, 0, CLS_INF, 0, 5'h18, 1, 2'h0, RES_QNAN_INDEF, 0);
		chk("c2_clear", 32'(status_word_q[C2_BIT]), 32'h0);
		run_op(OP_TRIG, CLS_INF, 1, CLS_FINITE, 0, 5'h10, 1, 2'h0, RES_QNAN_INDEF, 0);
		run_op(OP_SQRT, CLS_FINITE, 1, CLS_FINITE, 0, 5'h10, 1, 2'h0, RES_QNAN_INDEF, 0);
		run_op(OP_SQRT, CLS_ZERO, 1, CLS_FINITE, 0, 5'h10, 0, 2'h0, RES_NONE, 0);
		run_op(OP_YLOG, CLS_FINITE, 1, CLS_FINITE, 1, 5'h18, 1, 2'h0, RES_QNAN_INDEF, 0);
		run_op(OP_YLOGP1, CLS_FINITE, 1, CLS_FINITE, 0, 5'h1A, 1, 2'h0, RES_QNAN_INDEF, 0);
		run_op(OP_BCD_ST, CLS_FINITE, 0, CLS_FINITE, 0, 5'h11, 1, 2'h0, RES_BCD_INDEF, 0);
		run_op(OP_BCD_ST, CLS_QNAN, 0, CLS_FINITE, 0, 5'h10, 1, 2'h0, RES_BCD_INDEF, 0);
		run_op(OP_INT_ST, CLS_FINITE, 0, CLS_FINITE, 0, 5'h11, 1, 2'h0, RES_INT_INDEF, 0);
		run_op(OP_INT_ST, CLS_INF, 0, CLS_FINITE, 0, 5'h10, 1, 2'h0, RES_INT_INDEF, 0);
		$display("test masked responses done");
		for (int i = 0; i < 32; i++)
		begin
			{tw, ia, ld} = {16'($urandom), 3'($urandom), i[0]};
			id = ia;
			f = fault_exp(ld, tw, ia);
			run_op(ld ? OP_LOAD : OP_STORE_FP, CLS_FINITE, 0, CLS_FINITE, 0, ld ? 5'h04 : 5'h10,
				f, {f, ld}, f ? RES_QNAN_INDEF : RES_NONE, 0);
		end
		$display("test random tags done");
		{tw, ia, id} = '0;
		apb(1'b1, ADDR_CTRL, 32'h0);
		unm = 1'b1;
		run_op(OP_ADD, CLS_INF, 1, CLS_INF, 0, 5'h18, 1, 2'h0, RES_QNAN_INDEF, 0);
		run_op(OP_LOAD, CLS_FINITE, 0, CLS_FINITE, 0, 5'h04, 1, 2'h3, RES_QNAN_INDEF, 0);
		run_op(OP_ADD, CLS_FINITE, 0, CLS_FINITE, 0, 5'h18, 0, 2'h0, RES_NONE, 0);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk("stat_read", rd, 32'h0000_43C1);
		$display("test unmasked done");
		summarize();
	end

	initial
	begin
		repeat (5000) @(posedge pclk);
		errors++;
		summarize();
	end
endmodule
